// ===== include/scms_map.svh
// Offsets, field positions, reset values and timing counts of the mode sequencer.
// Assumes a 50 MHz pclk and an APB slave with 32-bit aligned registers.
// Notes on behaviour
// - After power-on, self-diagnose with run flashing green and debug dark.
// - PROGRAM: safety comms and programs halted, both indicators dark, downloads accepted.
// - RUN: comms running, validated programs only, run green, debug dark.
// - Debug stopped: comms on, programs idle, forcing allowed, run dark, debug yellow.
// - Debug running: comms on, programs run, forcing allowed, both indicators lit.
// - RESTORE: no comms, no programs, both indicators flash.
// - Mode is independent of the host controller mode in both directions.
// - Forced refresh is refused outside the two debug sub-modes.
// - Debug is entered only on request from an online tool session.
// - Session lost in debug: fall back to PROGRAM after 30 seconds.
// - At most one tool session; further openings are refused.
// - Initializing and RESTORE: inputs ignored, outputs and status word cleared.
// - PROGRAM: inputs ignored, outputs cleared, status refreshed; else all refresh.
// - PROGRAM to debug or RUN starts exchange; RUN also initializes and restarts.
// - Debug sub-mode switch reinitializes; to running restarts, to stopped clears forcing.
// - Entering PROGRAM stops exchange and zeroes received and sent safety data.
// - RUN or debug running to PROGRAM reinitializes variables and halts programs.
// - Debug running to PROGRAM also clears every forced state.
// - RUN to PROGRAM erases stored safety programs from non-volatile storage.
// - After initialization go to RUN if a validated application exists, else PROGRAM.
// - PROGRAM to debug erases stored safety application data.
`ifndef SCMS_MAP_SVH
`define SCMS_MAP_SVH
`define SCMS_OFF_CMD 8'h00
`define SCMS_OFF_STATUS 8'h04
`define SCMS_OFF_FLASH 8'h08
`define SCMS_OFF_SWORD 8'h0C
`define SCMS_OFF_FLAGS 8'h10
`define SCMS_CMD_PROGRAM 0
`define SCMS_CMD_RUN 1
`define SCMS_CMD_DBG_STOP 2
`define SCMS_CMD_DBG_RUN 3
`define SCMS_CMD_RESTORE 4
`define SCMS_CMD_SESS_OPEN 5
`define SCMS_CMD_SESS_CLOSE 6
`define SCMS_CMD_FORCE 7
`define SCMS_FLG_FORCE_REJ 0
`define SCMS_FLG_SESS_REJ 1
`define SCMS_FLG_MODE_REJ 2
`define SCMS_CLK_HZ 32'd50000000
`define SCMS_FALLBACK_S 32'd30
`define SCMS_FALLBACK_CYC (`SCMS_FALLBACK_S * `SCMS_CLK_HZ)
`define SCMS_FLASH_HALF_MS 32'd250
`define SCMS_FLASH_RST (`SCMS_FLASH_HALF_MS * (`SCMS_CLK_HZ / 32'd1000))
`endif

// ===== include/scms_pkg.sv
// Types shared by the mode sequencer.
// Assumes nothing beyond the map header for numeric values.
package scms_pkg;
  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_PROGRAM,
    MODE_RUN,
    MODE_DBG_STOP,
    MODE_DBG_RUN,
    MODE_RESTORE
  } scms_mode_t;
endpackage

// ===== design/scms_mode_seq.sv
// Operating-mode sequencer: modes, indicators, I/O data gating and transition actions.
// Assumes APB from a single master, all inputs synchronous to pclk.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "scms_map.svh"
module scms_mode_seq #(
  parameter int SAFE_W = 32,
  parameter int STD_W = 32,
  parameter int STAT_W = 16,
  parameter logic [31:0] FALLBACK_CYCLES = `SCMS_FALLBACK_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Unit status inputs
  input wire logic selftest_done,
  input wire logic app_validated,
  input wire logic tool_link_ok,
  input wire logic force_refresh_req,
  // Process data sources
  input wire logic [SAFE_W-1:0] safety_in,
  input wire logic [STD_W-1:0] std_in,
  input wire logic [SAFE_W-1:0] safety_out_src,
  input wire logic [STD_W-1:0] std_out_src,
  input wire logic [STAT_W-1:0] status_src,
  // Gated process data
  output logic [SAFE_W-1:0] safety_in_q,
  output logic [STD_W-1:0] std_in_q,
  output logic [SAFE_W-1:0] safety_out,
  output logic [STD_W-1:0] std_out,
  output logic [STAT_W-1:0] status_word,
  // Indicators
  output logic run_led_green,
  output logic debug_led_yellow,
  // Execution levels and transition actions
  output logic comm_active,
  output logic prog_exec,
  output logic forcing_active,
  output logic force_refresh_ack,
  output logic comm_start_pulse,
  output logic comm_stop_pulse,
  output logic var_init_pulse,
  output logic prog_restart_pulse,
  output logic force_clear_pulse,
  output logic erase_prog_pulse,
  output logic erase_app_pulse
);
  scms_pkg::scms_mode_t mode_reg, mode_next;
  logic [31:0] flash_reg, flash_cnt_reg, flash_lim, fallback_cnt_reg, prdata_reg;
  logic [2:0] flags_reg;
  logic [7:0] cmd;
  logic flash_phase_reg, session_reg, wr, rd_setup, mapped, mode_rej, is_dbg, fallback_hit;

  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign mapped = (paddr == `SCMS_OFF_CMD) || (paddr == `SCMS_OFF_STATUS) ||
                  (paddr == `SCMS_OFF_FLASH) || (paddr == `SCMS_OFF_SWORD) ||
                  (paddr == `SCMS_OFF_FLAGS);
  // Registers answer without wait states; read data is captured in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign cmd = (wr && paddr == `SCMS_OFF_CMD) ? pwdata[7:0] : 8'h00;
  assign is_dbg = (mode_reg == scms_pkg::MODE_DBG_STOP) || (mode_reg == scms_pkg::MODE_DBG_RUN);
  assign fallback_hit = is_dbg && !session_reg && (fallback_cnt_reg >= FALLBACK_CYCLES - 32'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      if (paddr == `SCMS_OFF_STATUS) begin
        prdata_reg <= {24'h000000, forcing_active, prog_exec, comm_active, session_reg,
                       1'b0, 3'(mode_reg)};
      end else if (paddr == `SCMS_OFF_FLASH) begin
        prdata_reg <= flash_reg;
      end else if (paddr == `SCMS_OFF_SWORD) begin
        prdata_reg <= 32'(status_word);
      end else if (paddr == `SCMS_OFF_FLAGS) begin
        prdata_reg <= {29'h00000000, flags_reg};
      end else begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_reg <= `SCMS_FLASH_RST;
    end else if (wr && paddr == `SCMS_OFF_FLASH) begin
      flash_reg <= pwdata;
    end
  end

  // A single shared toggle keeps both flashing indicators in step.
  assign flash_lim = (flash_reg == 32'h00000000) ? 32'h00000000 : flash_reg - 32'd1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_reg <= 32'h00000000;
      flash_phase_reg <= 1'b0;
    end else if (flash_cnt_reg >= flash_lim) begin
      flash_cnt_reg <= 32'h00000000;
      flash_phase_reg <= !flash_phase_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 32'd1;
    end
  end

  // Mode changes come only from local commands, the self-test and the fallback timer;
  // no host controller mode enters here and none leaves.
  always_comb begin
    mode_next = mode_reg;
    mode_rej = 1'b0;
    case (mode_reg)
      scms_pkg::MODE_INIT: begin
        if (selftest_done) begin
          mode_next = app_validated ? scms_pkg::MODE_RUN : scms_pkg::MODE_PROGRAM;
        end
      end
      scms_pkg::MODE_PROGRAM: begin
        if (cmd[`SCMS_CMD_RUN]) begin
          if (app_validated) begin
            mode_next = scms_pkg::MODE_RUN;
          end else begin
            mode_rej = 1'b1;
          end
        end else if (cmd[`SCMS_CMD_DBG_STOP]) begin
          if (session_reg) begin
            mode_next = scms_pkg::MODE_DBG_STOP;
          end else begin
            mode_rej = 1'b1;
          end
        end else if (cmd[`SCMS_CMD_RESTORE]) begin
          mode_next = scms_pkg::MODE_RESTORE;
        end else if (cmd[`SCMS_CMD_DBG_RUN]) begin
          mode_rej = 1'b1;
        end
      end
      scms_pkg::MODE_RUN: begin
        if (cmd[`SCMS_CMD_PROGRAM]) begin
          mode_next = scms_pkg::MODE_PROGRAM;
        end else if (cmd[`SCMS_CMD_DBG_STOP] || cmd[`SCMS_CMD_DBG_RUN]) begin
          mode_rej = 1'b1;
        end
      end
      scms_pkg::MODE_DBG_STOP, scms_pkg::MODE_DBG_RUN: begin
        if (fallback_hit || cmd[`SCMS_CMD_PROGRAM]) begin
          mode_next = scms_pkg::MODE_PROGRAM;
        end else if (cmd[`SCMS_CMD_DBG_RUN]) begin
          mode_next = scms_pkg::MODE_DBG_RUN;
        end else if (cmd[`SCMS_CMD_DBG_STOP]) begin
          mode_next = scms_pkg::MODE_DBG_STOP;
        end
      end
      scms_pkg::MODE_RESTORE: begin
        if (cmd[`SCMS_CMD_PROGRAM]) begin
          mode_next = scms_pkg::MODE_PROGRAM;
        end
      end
      default: mode_next = scms_pkg::MODE_INIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= scms_pkg::MODE_INIT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      session_reg <= 1'b0;
    end else if (!tool_link_ok || cmd[`SCMS_CMD_SESS_CLOSE]) begin
      session_reg <= 1'b0;
    end else if (cmd[`SCMS_CMD_SESS_OPEN]) begin
      session_reg <= 1'b1;
    end
  end

  // The timer restarts whenever a session is present, so a reconnection cancels it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fallback_cnt_reg <= 32'h00000000;
    end else if (!is_dbg || session_reg || fallback_hit) begin
      fallback_cnt_reg <= 32'h00000000;
    end else begin
      fallback_cnt_reg <= fallback_cnt_reg + 32'd1;
    end
  end

  // Sticky refusal flags; a new refusal wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= 3'h0;
    end else begin
      flags_reg[`SCMS_FLG_FORCE_REJ] <= (!is_dbg && (cmd[`SCMS_CMD_FORCE] || force_refresh_req)) ||
        (flags_reg[`SCMS_FLG_FORCE_REJ] &&
         !(wr && paddr == `SCMS_OFF_FLAGS && pwdata[`SCMS_FLG_FORCE_REJ]));
      flags_reg[`SCMS_FLG_SESS_REJ] <= (cmd[`SCMS_CMD_SESS_OPEN] &&
        (session_reg || !tool_link_ok)) || (flags_reg[`SCMS_FLG_SESS_REJ] &&
         !(wr && paddr == `SCMS_OFF_FLAGS && pwdata[`SCMS_FLG_SESS_REJ]));
      flags_reg[`SCMS_FLG_MODE_REJ] <= mode_rej || (flags_reg[`SCMS_FLG_MODE_REJ] &&
         !(wr && paddr == `SCMS_OFF_FLAGS && pwdata[`SCMS_FLG_MODE_REJ]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forcing_active <= 1'b0;
      force_refresh_ack <= 1'b0;
    end else begin
      force_refresh_ack <= is_dbg && force_refresh_req;
      if (!is_dbg || mode_next != mode_reg) begin
        forcing_active <= 1'b0;
      end else if (cmd[`SCMS_CMD_FORCE]) begin
        forcing_active <= 1'b1;
      end
    end
  end

  // Indicators and execution levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_led_green <= 1'b0;
      debug_led_yellow <= 1'b0;
      comm_active <= 1'b0;
      prog_exec <= 1'b0;
    end else begin
      case (mode_reg)
        scms_pkg::MODE_INIT: begin
          run_led_green <= flash_phase_reg;
          debug_led_yellow <= 1'b0;
        end
        scms_pkg::MODE_RUN: begin
          run_led_green <= 1'b1;
          debug_led_yellow <= 1'b0;
        end
        scms_pkg::MODE_DBG_STOP: begin
          run_led_green <= 1'b0;
          debug_led_yellow <= 1'b1;
        end
        scms_pkg::MODE_DBG_RUN: begin
          run_led_green <= 1'b1;
          debug_led_yellow <= 1'b1;
        end
        scms_pkg::MODE_RESTORE: begin
          run_led_green <= flash_phase_reg;
          debug_led_yellow <= flash_phase_reg;
        end
        default: begin
          run_led_green <= 1'b0;
          debug_led_yellow <= 1'b0;
        end
      endcase
      comm_active <= (mode_reg == scms_pkg::MODE_RUN) || is_dbg;
      prog_exec <= (mode_reg == scms_pkg::MODE_RUN) ||
                   (mode_reg == scms_pkg::MODE_DBG_RUN);
    end
  end

  // Process data gating by mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_in_q <= '0;
      std_in_q <= '0;
      safety_out <= '0;
      std_out <= '0;
      status_word <= '0;
    end else begin
      if ((mode_reg == scms_pkg::MODE_RUN) || is_dbg) begin
        safety_in_q <= safety_in;
        std_in_q <= std_in;
        safety_out <= safety_out_src;
        std_out <= std_out_src;
      end else begin
        safety_in_q <= '0;
        std_in_q <= '0;
        safety_out <= '0;
        std_out <= '0;
      end
      if ((mode_reg == scms_pkg::MODE_INIT) || (mode_reg == scms_pkg::MODE_RESTORE)) begin
        status_word <= '0;
      end else begin
        status_word <= status_src;
      end
    end
  end

  // One-cycle action pulses, registered on the same edge at which the mode register changes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comm_start_pulse <= 1'b0;
      comm_stop_pulse <= 1'b0;
      var_init_pulse <= 1'b0;
      prog_restart_pulse <= 1'b0;
      force_clear_pulse <= 1'b0;
      erase_prog_pulse <= 1'b0;
      erase_app_pulse <= 1'b0;
    end else begin
      comm_start_pulse <= (mode_reg == scms_pkg::MODE_PROGRAM) &&
        (mode_next == scms_pkg::MODE_RUN || mode_next == scms_pkg::MODE_DBG_STOP);
      comm_stop_pulse <= (mode_next == scms_pkg::MODE_PROGRAM) &&
        ((mode_reg == scms_pkg::MODE_RUN) || is_dbg);
      var_init_pulse <= (mode_reg != mode_next) &&
        ((mode_next == scms_pkg::MODE_RUN && mode_reg == scms_pkg::MODE_PROGRAM) ||
         (is_dbg && mode_next != scms_pkg::MODE_PROGRAM) ||
         (mode_next == scms_pkg::MODE_PROGRAM && (mode_reg == scms_pkg::MODE_RUN ||
          mode_reg == scms_pkg::MODE_DBG_RUN)));
      prog_restart_pulse <= (mode_next == scms_pkg::MODE_RUN && mode_reg == scms_pkg::MODE_PROGRAM)
        || (mode_next == scms_pkg::MODE_DBG_RUN && mode_reg == scms_pkg::MODE_DBG_STOP);
      force_clear_pulse <= (mode_reg == scms_pkg::MODE_DBG_RUN) &&
        (mode_next == scms_pkg::MODE_DBG_STOP || mode_next == scms_pkg::MODE_PROGRAM);
      erase_prog_pulse <= (mode_reg == scms_pkg::MODE_RUN) &&
        (mode_next == scms_pkg::MODE_PROGRAM);
      erase_app_pulse <= (mode_reg == scms_pkg::MODE_PROGRAM) &&
        (mode_next == scms_pkg::MODE_DBG_STOP);
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_init_leds;
    (mode_reg == scms_pkg::MODE_INIT) |=> (run_led_green == $past(flash_phase_reg)) &&
      !debug_led_yellow;
  endproperty
  a_init_leds: assert property (p_init_leds) else $error("init indicators wrong");
  property p_program_dark;
    (mode_reg == scms_pkg::MODE_PROGRAM) |=> !run_led_green && !debug_led_yellow &&
      !prog_exec && !comm_active;
  endproperty
  a_program_dark: assert property (p_program_dark) else $error("program not dark");
  property p_dbg_stop;
    (mode_reg == scms_pkg::MODE_DBG_STOP) |=> !run_led_green && debug_led_yellow &&
      comm_active && !prog_exec;
  endproperty
  a_dbg_stop: assert property (p_dbg_stop) else $error("debug stop state wrong");
  property p_restore;
    (mode_reg == scms_pkg::MODE_RESTORE) |=> !comm_active &&
      (debug_led_yellow == $past(flash_phase_reg)) && (status_word == '0);
  endproperty
  a_restore: assert property (p_restore) else $error("restore state wrong");
  property p_force_rej;
    (!is_dbg && force_refresh_req) |=> flags_reg[`SCMS_FLG_FORCE_REJ] && !force_refresh_ack;
  endproperty
  a_force_rej: assert property (p_force_rej) else $error("forced refresh not refused");
  property p_dbg_entry;
    (mode_reg == scms_pkg::MODE_PROGRAM && mode_next == scms_pkg::MODE_DBG_STOP) |->
      session_reg ##1 erase_app_pulse;
  endproperty
  a_dbg_entry: assert property (p_dbg_entry) else $error("debug entry wrong");
  property p_fallback;
    fallback_hit |=> (mode_reg == scms_pkg::MODE_PROGRAM) ##1 (safety_in_q == '0);
  endproperty
  a_fallback: assert property (p_fallback) else $error("fallback missed");
  property p_one_session;
    (session_reg && cmd[`SCMS_CMD_SESS_OPEN]) |=> flags_reg[`SCMS_FLG_SESS_REJ];
  endproperty
  a_one_session: assert property (p_one_session) else $error("second session taken");
  property p_run_to_prog;
    (mode_reg == scms_pkg::MODE_RUN && mode_next == scms_pkg::MODE_PROGRAM) |=>
      erase_prog_pulse && var_init_pulse && comm_stop_pulse ##1 !erase_prog_pulse;
  endproperty
  a_run_to_prog: assert property (p_run_to_prog) else $error("run exit actions wrong");
endmodule

// ===== test/scms_tool_model.sv
// Behavioural model of the configuration tool's physical link to the sequencer.
// Assumes the bench asks it to connect or drop; the link comes up CONNECT_CYC + 1 cycles later.
`timescale 1ns/1ps
module scms_tool_model #(
  parameter int CONNECT_CYC = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic want_online,
  // Link to the device
  output logic tool_link_ok
);
  int cnt;

  // The link is up before each accepted debug request is made, and there is only one tool.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      tool_link_ok <= 1'b0;
    end else if (!want_online) begin
      cnt <= 0;
      tool_link_ok <= 1'b0;
    end else if (cnt < CONNECT_CYC) begin
      cnt <= cnt + 1;
    end else begin
      tool_link_ok <= 1'b1;
    end
  end
endmodule

// ===== test/tb.sv
// Self-checking bench for the mode sequencer, driven over APB with a tool link model.
// Assumes a 50 MHz pclk and the fallback count shortened to 50 cycles.
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, seen;
  logic [31:0] pwdata, prdata, r;
  logic selftest_done, app_validated, tool_link_ok, force_refresh_req, want_online;
  logic [31:0] safety_in, std_in, safety_out_src, std_out_src, safety_in_q, std_in_q;
  logic [31:0] safety_out, std_out;
  logic [15:0] status_src, status_word;
  logic run_led_green, debug_led_yellow, comm_active, prog_exec, forcing_active;
  logic force_refresh_ack, comm_start_pulse, comm_stop_pulse, var_init_pulse;
  logic prog_restart_pulse, force_clear_pulse, erase_prog_pulse, erase_app_pulse;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;

  scms_mode_seq #(.FALLBACK_CYCLES(32'd50)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .selftest_done, .app_validated, .tool_link_ok, .force_refresh_req,
    .safety_in, .std_in, .safety_out_src, .std_out_src, .status_src, .safety_in_q,
    .std_in_q, .safety_out, .std_out, .status_word, .run_led_green, .debug_led_yellow,
    .comm_active, .prog_exec, .forcing_active, .force_refresh_ack, .comm_start_pulse,
    .comm_stop_pulse, .var_init_pulse, .prog_restart_pulse, .force_clear_pulse,
    .erase_prog_pulse, .erase_app_pulse
  );

  scms_tool_model i_tool (.pclk, .presetn, .want_online, .tool_link_ok);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Pulses are collected rather than sampled so that their exact cycle does not matter.
  always @(posedge pclk) begin
    seen <= seen | {force_refresh_ack, comm_start_pulse, comm_stop_pulse, var_init_pulse,
      prog_restart_pulse, force_clear_pulse, erase_prog_pulse, erase_app_pulse};
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task close_out;
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] b);
    @(negedge pclk);
    seen = 8'h00;
    apb(1'b1, 8'h00, {24'h000000, b});
    wt(3);
  endtask

  task automatic mode(input logic [2:0] m);
    apb(1'b0, 8'h04, 32'h00000000);
    chk({29'h0, r[2:0]}, {29'h0, m});
  endtask

  task automatic flag(input int b);
    apb(1'b0, 8'h10, 32'h00000000);
    chk({31'h0, r[b]}, 32'h00000001);
    apb(1'b1, 8'h10, 32'h00000007);
  endtask

  task automatic leds(input logic [1:0] e);
    chk({30'h0, run_led_green, debug_led_yellow}, {30'h0, e});
  endtask

  task frq;
    @(negedge pclk);
    seen = 8'h00;
    @(posedge pclk);
    force_refresh_req <= 1'b1;
    @(posedge pclk);
    force_refresh_req <= 1'b0;
    wt(2);
  endtask

  // Both indicators are watched together; with dual clear the debug one must stay dark.
  task automatic flash(input logic dual);
    logic p;
    int tog;
    int d;
    tog = 0;
    d = 0;
    @(negedge pclk);
    p = run_led_green;
    repeat (24) begin
      @(negedge pclk);
      if (run_led_green !== p) tog++;
      if (debug_led_yellow !== (dual ? run_led_green : 1'b0)) d++;
      p = run_led_green;
    end
    chk(32'(tog), 32'h00000006);
    chk(32'(d), 32'h00000000);
  endtask

  task t_init;
    apb(1'b1, 8'h08, 32'h00000004);
    apb(1'b0, 8'h08, 32'h00000000);
    chk(r, 32'h00000004);
    mode(3'h0);
    flash(1'b0);
    chk({16'h0, status_word}, 32'h00000000);
    chk(safety_out, 32'h00000000);
    @(posedge pclk);
    selftest_done <= 1'b1;
    wt(4);
    mode(3'h1);
  endtask

  task t_program;
    leds(2'b00);
    chk({31'h0, comm_active}, 32'h00000000);
    chk({16'h0, status_word}, {16'h0, status_src});
    chk(safety_in_q, 32'h00000000);
    chk(std_out, 32'h00000000);
    apb(1'b0, 8'h0C, 32'h00000000);
    chk(r, {16'h0, status_src});
    frq;
    chk({31'h0, seen[7]}, 32'h00000000);
    flag(0);
    cmd(8'h04);
    flag(2);
    mode(3'h1);
  endtask

  task t_debug;
    @(posedge pclk);
    want_online <= 1'b1;
    wt(6);
    cmd(8'h20);
    apb(1'b0, 8'h04, 32'h00000000);
    chk({31'h0, r[4]}, 32'h00000001);
    cmd(8'h20);
    flag(1);
    cmd(8'h04);
    chk({24'h0, seen}, 32'h00000041);
    leds(2'b01);
    chk(safety_in_q, safety_in);
    chk(std_out, std_out_src);
    frq;
    chk({31'h0, seen[7]}, 32'h00000001);
    cmd(8'h08);
    chk({24'h0, seen}, 32'h00000018);
    leds(2'b11);
    chk({31'h0, prog_exec}, 32'h00000001);
    cmd(8'h80);
    chk({31'h0, forcing_active}, 32'h00000001);
    cmd(8'h04);
    chk({24'h0, seen}, 32'h00000014);
    chk({31'h0, forcing_active}, 32'h00000000);
    cmd(8'h08);
    cmd(8'h80);
    chk({31'h0, forcing_active}, 32'h00000001);
    cmd(8'h01);
    chk({24'h0, seen}, 32'h00000034);
    chk({31'h0, forcing_active}, 32'h00000000);
    chk(safety_in_q, 32'h00000000);
    chk(safety_out, 32'h00000000);
  endtask

  task t_fallback;
    cmd(8'h04);
    mode(3'h3);
    @(posedge pclk);
    want_online <= 1'b0;
    wt(35);
    mode(3'h3);
    wt(20);
    mode(3'h1);
  endtask

  task t_run;
    @(posedge pclk);
    app_validated <= 1'b1;
    cmd(8'h02);
    chk({24'h0, seen}, 32'h00000058);
    leds(2'b10);
    chk({30'h0, comm_active, prog_exec}, 32'h00000003);
    chk(std_in_q, std_in);
    chk(safety_out, safety_out_src);
    apb(1'b0, 8'h04, 32'h00000000);
    chk({30'h0, r[6:5]}, 32'h00000003);
    frq;
    chk({31'h0, seen[7]}, 32'h00000000);
    cmd(8'h04);
    flag(2);
    cmd(8'h01);
    chk({24'h0, seen}, 32'h00000032);
  endtask

  task t_restore;
    cmd(8'h10);
    mode(3'h5);
    chk({16'h0, status_word}, 32'h00000000);
    chk(std_in_q, 32'h00000000);
    flash(1'b1);
    cmd(8'h01);
    mode(3'h1);
    apb(1'b0, 8'h40, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    chk(r, 32'h00000000);
  endtask

  // A second power-on with a validated application stored must come up in RUN.
  task t_reboot;
    @(posedge pclk);
    presetn <= 1'b0;
    selftest_done <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    mode(3'h0);
    @(posedge pclk);
    selftest_done <= 1'b1;
    wt(4);
    mode(3'h2);
    wt(0);
    leds(2'b10);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    seen = 8'h00;
    selftest_done = 1'b0;
    app_validated = 1'b0;
    force_refresh_req = 1'b0;
    want_online = 1'b0;
    safety_in = 32'hA5A50001;
    std_in = 32'h5A5A0002;
    safety_out_src = 32'hC3C30003;
    std_out_src = 32'h3C3C0004;
    status_src = 16'h5A3C;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_init;
    t_program;
    t_debug;
    t_fallback;
    t_run;
    t_restore;
    t_reboot;
    close_out;
  end
endmodule
